/* File: tbls_sequencer.sv */
// Tape block locate sequencer: command interpreter between computer and tape units
module tbls_sequencer #(
  parameter int UNITS = 4
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET,
  // Instruction port from the computer
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [3:0] CMD_OP,
  input wire logic [1:0] CMD_UNIT,
  input wire logic [tbls_pkg::MAG_W-1:0] CMD_KEY,
  input wire logic [7:0] CMD_FIELD_SPEC,
  input wire logic [tbls_pkg::ADDR_W-1:0] CMD_ADDR,
  input wire logic [3:0] CMD_COUNT,
  input wire logic [7:0] CMD_PREFACE,
  input wire logic CMD_LANE,
  // Completion report
  output logic DONE,
  output logic [2:0] DONE_CAUSE,
  output logic ALARM_MISMATCH,
  output logic ALARM_NOT_READY,
  // Storage write port
  output logic MEM_WE,
  output logic [tbls_pkg::ADDR_W-1:0] MEM_ADDR,
  output logic [tbls_pkg::WORD_W-1:0] MEM_DATA,
  // Tape unit control
  output logic [1:0] TAPE_UNIT,
  output logic TAPE_FWD,
  output logic TAPE_BWD,
  output logic TAPE_STOP,
  output logic TAPE_STOP_POS,
  output logic TAPE_WRITE_GO,
  output logic REWIND_GO,
  output logic LANE_GO,
  output logic HEAD_LANE,
  // Tape unit read stream, same clock
  input wire logic TAPE_BLK_START,
  input wire logic [7:0] TAPE_PREFACE,
  input wire logic TAPE_EOT_BLOCK,
  input wire logic TAPE_WORD_VALID,
  input wire logic [tbls_pkg::WORD_W-1:0] TAPE_WORD,
  input wire logic TAPE_WORD_LAST,
  input wire logic TAPE_BLANK,
  input wire logic TAPE_NEW_TAPE,
  input wire logic TAPE_PHYS_END,
  // Operator pins, asynchronous
  input wire logic [UNITS-1:0] OPERATOR_RELEASE,
  input wire logic OPERATOR_HALT,
  output logic [UNITS-1:0] UNIT_LOCKED
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Field mask: spec high digit is lowest digit of field, low digit its length
  function automatic logic [tbls_pkg::MAG_W-1:0] field_mask(input logic field_en,
                                                            input logic [7:0] spec);
    logic [tbls_pkg::MAG_W-1:0] m;
    logic [4:0] lo;
    logic [4:0] len;
    m = '0;
    lo = {1'b0, spec[7:4]};
    len = (spec[3:0] == 4'h0) ? tbls_pkg::FULL_FIELD : {1'b0, spec[3:0]};
    for (int i = 0; i < tbls_pkg::DIGITS; i++) begin
      if (!field_en || ((5'(i) >= lo) && (5'(i) < lo + len))) begin
        m[i*4 +: 4] = 4'hf;
      end
    end
    return m;
  endfunction

  // BCD magnitude with sign digit dropped and field applied
  function automatic logic [tbls_pkg::MAG_W-1:0] masked(input logic [tbls_pkg::WORD_W-1:0] w,
                                                        input logic [tbls_pkg::MAG_W-1:0] m);
    return w[tbls_pkg::MAG_W-1:0] & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Operator pin synchronisers: a change counts once stages two and three agree

  logic [UNITS:0] pin_s1_reg;
  logic [UNITS:0] pin_s2_reg;
  logic [UNITS:0] pin_s3_reg;
  logic [UNITS:0] pin_level_reg;

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= {OPERATOR_HALT, OPERATOR_RELEASE};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  // Filtered level follows only agreeing bits
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      pin_level_reg <= '0;
    end else begin
      for (int i = 0; i <= UNITS; i++) begin
        if (pin_s2_reg[i] == pin_s3_reg[i]) begin
          pin_level_reg[i] <= pin_s3_reg[i];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command latch and decode

  tbls_pkg::tbls_state_t state_reg;
  tbls_pkg::tbls_op_t op_reg;
  logic [tbls_pkg::MAG_W-1:0] key_reg;
  logic [tbls_pkg::MAG_W-1:0] mask_reg;
  logic [7:0] preface_reg;
  logic [3:0] count_reg;
  logic eoi_reg;
  logic [tbls_pkg::ADDR_W-1:0] addr_reg;
  logic [3:0] word_idx_reg;
  logic first_word_reg;
  logic eot_blk_reg;
  logic scan_hit_reg;
  logic ctrl_blk_reg;

  tbls_pkg::tbls_op_t cmd_op;
  logic accept;
  logic unit_locked;
  logic field_op;
  logic [3:0] count_clamped;

  assign cmd_op = tbls_pkg::tbls_op_t'(CMD_OP);
  assign CMD_READY = (state_reg == tbls_pkg::ST_IDLE); // [RULE6]
  assign accept = CMD_VALID && CMD_READY;
  assign unit_locked = UNIT_LOCKED[CMD_UNIT];
  assign field_op = (cmd_op == tbls_pkg::OP_FIELD_KEYED_SEARCH) ||
                    (cmd_op == tbls_pkg::OP_FIELD_CATEGORY_SCAN);
  // Counts outside one to ten are pinned to the nearest legal value
  assign count_clamped = (CMD_COUNT == 4'h0) ? 4'h1 :
                         (CMD_COUNT > tbls_pkg::MAX_BLOCKS) ? tbls_pkg::MAX_BLOCKS :
                         CMD_COUNT; // [RULE11] [RULE18]

  ////////////////////////////////////////////////////////////////////////////
  // Block stream decode

  logic [tbls_pkg::MAG_W-1:0] word_mag;
  logic [tbls_pkg::MAG_W-1:0] key_mag;
  logic first_word;
  logic ctrl_first;
  logic ctrl_now;
  logic blk_end;
  logic key_ge;
  logic key_eq;
  logic key_lt;

  assign word_mag = masked(TAPE_WORD, mask_reg); // [RULE1] [RULE5] [RULE7] [RULE10]
  assign key_mag = key_reg & mask_reg;
  assign first_word = TAPE_WORD_VALID && first_word_reg;
  // A control mark in an end block is not honoured
  assign ctrl_first = first_word && !eot_blk_reg &&
                      (TAPE_WORD[tbls_pkg::WORD_W-1:tbls_pkg::SIGN_LO] ==
                       tbls_pkg::CTRL_SIGN); // [RULE24]
  assign ctrl_now = ctrl_first || ctrl_blk_reg;
  assign blk_end = TAPE_WORD_VALID && TAPE_WORD_LAST;
  // BCD orders like binary, so a plain compare serves
  assign key_ge = word_mag >= key_mag; // [RULE1]
  assign key_eq = word_mag == key_mag;
  assign key_lt = word_mag < key_mag;

  // Per-block trackers: first word, word index, block kind
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      first_word_reg <= 1'b0;
      word_idx_reg <= 4'h0;
      eot_blk_reg <= 1'b0;
      ctrl_blk_reg <= 1'b0;
    end else if (TAPE_BLK_START) begin
      first_word_reg <= 1'b1;
      word_idx_reg <= 4'h0;
      eot_blk_reg <= TAPE_EOT_BLOCK;
      ctrl_blk_reg <= 1'b0;
    end else if (TAPE_WORD_VALID) begin
      first_word_reg <= 1'b0;
      if (word_idx_reg != 4'hf) begin
        word_idx_reg <= word_idx_reg + 4'h1;
      end
      if (ctrl_first) begin
        ctrl_blk_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequencer

  // Ending a motion instruction: stop tape, report and go idle
  task automatic finish(input logic pos, input logic [2:0] cause);
    state_reg <= tbls_pkg::ST_IDLE;
    TAPE_FWD <= 1'b0;
    TAPE_BWD <= 1'b0;
    TAPE_STOP <= 1'b1;
    TAPE_STOP_POS <= pos;
    DONE <= 1'b1; // [RULE26]
    DONE_CAUSE <= cause;
  endtask

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      state_reg <= tbls_pkg::ST_IDLE;
      op_reg <= tbls_pkg::OP_KEYED_BLOCK_SEARCH;
      key_reg <= '0;
      mask_reg <= '0;
      preface_reg <= 8'h00;
      count_reg <= 4'h0;
      eoi_reg <= 1'b0;
      addr_reg <= '0;
      scan_hit_reg <= 1'b0;
      TAPE_UNIT <= 2'h0;
      TAPE_FWD <= 1'b0;
      TAPE_BWD <= 1'b0;
      TAPE_STOP <= 1'b0;
      TAPE_STOP_POS <= tbls_pkg::STOP_AT_NEXT;
      TAPE_WRITE_GO <= 1'b0;
      REWIND_GO <= 1'b0;
      LANE_GO <= 1'b0;
      HEAD_LANE <= 1'b0;
      DONE <= 1'b0;
      DONE_CAUSE <= tbls_pkg::CAUSE_COUNT;
      ALARM_MISMATCH <= 1'b0;
      ALARM_NOT_READY <= 1'b0;
      MEM_WE <= 1'b0;
      MEM_ADDR <= '0;
      MEM_DATA <= '0;
    end else begin
      TAPE_STOP <= 1'b0;
      TAPE_WRITE_GO <= 1'b0;
      REWIND_GO <= 1'b0;
      LANE_GO <= 1'b0;
      DONE <= 1'b0;
      ALARM_MISMATCH <= 1'b0;
      ALARM_NOT_READY <= 1'b0;
      MEM_WE <= 1'b0;
      case (state_reg)
        tbls_pkg::ST_IDLE: begin
          if (accept) begin
            op_reg <= cmd_op;
            key_reg <= CMD_KEY;
            mask_reg <= field_mask(field_op, CMD_FIELD_SPEC); // [RULE5] [RULE10]
            preface_reg <= CMD_PREFACE;
            count_reg <= count_clamped;
            addr_reg <= CMD_ADDR;
            scan_hit_reg <= 1'b0;
            eoi_reg <= 1'b0;
            TAPE_UNIT <= CMD_UNIT;
            if (unit_locked) begin
              DONE <= 1'b1; // [RULE21]
              DONE_CAUSE <= tbls_pkg::CAUSE_NOT_READY;
              ALARM_NOT_READY <= 1'b1;
            end else begin
              case (cmd_op)
                tbls_pkg::OP_KEYED_BLOCK_SEARCH, tbls_pkg::OP_FIELD_KEYED_SEARCH: begin
                  state_reg <= tbls_pkg::ST_SRCH_FWD;
                  TAPE_FWD <= 1'b1;
                end
                tbls_pkg::OP_CATEGORY_SCAN, tbls_pkg::OP_FIELD_CATEGORY_SCAN: begin
                  state_reg <= tbls_pkg::ST_SCAN;
                  TAPE_FWD <= 1'b1; // [RULE8]
                end
                tbls_pkg::OP_FIXED_LENGTH_READ, tbls_pkg::OP_READ_WITH_PREFACE: begin
                  state_reg <= tbls_pkg::ST_READ;
                  TAPE_FWD <= 1'b1;
                end
                tbls_pkg::OP_BLOCK_OVERWRITE, tbls_pkg::OP_OVERWRITE_WITH_PREFACE: begin
                  // Fresh tape holds no preface to check, so nothing is written
                  state_reg <= TAPE_NEW_TAPE ? tbls_pkg::ST_RUNOUT : tbls_pkg::ST_OVWR; // [RULE15]
                  TAPE_FWD <= 1'b1;
                end
                tbls_pkg::OP_SKIP_BLOCKS_FORWARD, tbls_pkg::OP_SEEK_END_OF_INFORMATION: begin
                  state_reg <= tbls_pkg::ST_SKIP;
                  eoi_reg <= (cmd_op == tbls_pkg::OP_SEEK_END_OF_INFORMATION);
                  TAPE_FWD <= 1'b1;
                end
                tbls_pkg::OP_SKIP_BLOCKS_BACKWARD: begin
                  state_reg <= tbls_pkg::ST_SKIP;
                  TAPE_BWD <= 1'b1; // [RULE18]
                end
                tbls_pkg::OP_TAPE_REWIND, tbls_pkg::OP_REWIND_AND_LOCK_UNIT: begin
                  REWIND_GO <= 1'b1; // [RULE20]
                  DONE <= 1'b1;
                  DONE_CAUSE <= tbls_pkg::CAUSE_COUNT;
                end
                tbls_pkg::OP_HEAD_LANE_CHOOSE: begin
                  LANE_GO <= 1'b1; // [RULE22]
                  HEAD_LANE <= CMD_LANE;
                  DONE <= 1'b1;
                  DONE_CAUSE <= tbls_pkg::CAUSE_COUNT;
                end
                default: begin
                  DONE <= 1'b1;
                  DONE_CAUSE <= tbls_pkg::CAUSE_BAD_OP;
                end
              endcase
            end
          end
        end
        tbls_pkg::ST_SRCH_FWD: begin
          if (TAPE_BLK_START && TAPE_EOT_BLOCK) begin
            finish(tbls_pkg::STOP_AT_THIS, tbls_pkg::CAUSE_EOT); // [RULE23]
          end else if (first_word && key_ge) begin
            state_reg <= tbls_pkg::ST_SRCH_BWD; // [RULE2]
            TAPE_FWD <= 1'b0;
            TAPE_BWD <= 1'b1;
          end
        end
        tbls_pkg::ST_SRCH_BWD: begin
          // End blocks pass as ordinary ones going backward
          if (first_word && key_eq) begin
            finish(tbls_pkg::STOP_AT_THIS, tbls_pkg::CAUSE_MATCH); // [RULE3] [RULE23]
          end else if (first_word && key_lt) begin
            finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_COUNT); // [RULE4]
          end
        end
        tbls_pkg::ST_SCAN: begin
          if (TAPE_BLK_START && TAPE_EOT_BLOCK) begin
            finish(tbls_pkg::STOP_AT_THIS, tbls_pkg::CAUSE_EOT); // [RULE9]
          end else if (ctrl_first) begin
            finish(tbls_pkg::STOP_AT_THIS, tbls_pkg::CAUSE_CTRL); // [RULE9]
          end else if (blk_end &&
                       (scan_hit_reg || (key_eq && word_idx_reg < tbls_pkg::SCAN_WORDS))) begin
            finish(tbls_pkg::STOP_AT_THIS, tbls_pkg::CAUSE_MATCH); // [RULE8]
          end else if (TAPE_BLK_START) begin
            scan_hit_reg <= 1'b0;
          end else if (TAPE_WORD_VALID && key_eq && word_idx_reg < tbls_pkg::SCAN_WORDS) begin
            scan_hit_reg <= 1'b1; // [RULE7]
          end
        end
        tbls_pkg::ST_READ: begin
          if (TAPE_BLK_START) begin
            if (op_reg == tbls_pkg::OP_READ_WITH_PREFACE) begin
              MEM_WE <= 1'b1; // [RULE13]
              MEM_ADDR <= addr_reg;
              MEM_DATA <= '0;
              MEM_DATA[tbls_pkg::PREF_HI:tbls_pkg::PREF_LO] <= TAPE_PREFACE;
              addr_reg <= addr_reg + 1'b1;
            end
            if (TAPE_EOT_BLOCK) begin
              finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_EOT); // [RULE14]
            end
          end else if (TAPE_WORD_VALID) begin
            // The closing control word of a control block is not stored
            if (!(ctrl_now && TAPE_WORD_LAST)) begin
              MEM_WE <= 1'b1; // [RULE12] [RULE25]
              MEM_ADDR <= addr_reg;
              MEM_DATA <= TAPE_WORD;
              addr_reg <= addr_reg + 1'b1;
            end
            if (TAPE_WORD_LAST) begin
              if (ctrl_now) begin
                finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_CTRL); // [RULE14] [RULE25]
              end else if (count_reg == 4'h1) begin
                finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_COUNT); // [RULE11]
              end else begin
                count_reg <= count_reg - 4'h1;
              end
            end
          end
        end
        tbls_pkg::ST_OVWR: begin
          // Any block kind may be rewritten when prefaces agree
          if (TAPE_BLK_START) begin
            if (TAPE_PREFACE == preface_reg) begin
              TAPE_WRITE_GO <= 1'b1; // [RULE16] [RULE17]
              finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_COUNT);
            end else if (TAPE_EOT_BLOCK) begin
              finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_EOT); // [RULE16]
            end else begin
              ALARM_MISMATCH <= 1'b1; // [RULE16]
              finish(tbls_pkg::STOP_AT_THIS, tbls_pkg::CAUSE_MISMATCH);
            end
          end
        end
        tbls_pkg::ST_SKIP: begin
          // End and control blocks count as ordinary blocks here
          if (eoi_reg && TAPE_BLANK) begin
            finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_COUNT); // [RULE19]
          end else if (!eoi_reg && blk_end) begin
            if (count_reg == 4'h1) begin
              finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_COUNT); // [RULE18]
            end else begin
              count_reg <= count_reg - 4'h1;
            end
          end
        end
        tbls_pkg::ST_RUNOUT: begin
          if (TAPE_PHYS_END || pin_level_reg[UNITS]) begin
            finish(tbls_pkg::STOP_AT_NEXT, tbls_pkg::CAUSE_RUNOUT); // [RULE15]
          end
        end
        default: begin
          state_reg <= tbls_pkg::ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Unit interlocks: set by the locking rewind, cleared by operator release

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      UNIT_LOCKED <= '0;
    end else begin
      for (int i = 0; i < UNITS; i++) begin
        // Set wins over a release seen in the same cycle
        if (accept && !unit_locked && cmd_op == tbls_pkg::OP_REWIND_AND_LOCK_UNIT &&
            CMD_UNIT == 2'(i)) begin
          UNIT_LOCKED[i] <= 1'b1; // [RULE21]
        end else if (pin_level_reg[i]) begin
          UNIT_LOCKED[i] <= 1'b0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_busy_no_accept: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE6]
    state_reg != tbls_pkg::ST_IDLE |-> !CMD_READY)
    else $error("command accepted while busy");

  a_search_reverse: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE2]
    state_reg == tbls_pkg::ST_SRCH_FWD && !TAPE_BLK_START && first_word && key_ge
    |=> state_reg == tbls_pkg::ST_SRCH_BWD && TAPE_BWD && !TAPE_FWD)
    else $error("search did not reverse");

  a_search_match: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE3]
    state_reg == tbls_pkg::ST_SRCH_BWD && first_word && key_eq
    |=> DONE && TAPE_STOP && TAPE_STOP_POS == tbls_pkg::STOP_AT_THIS)
    else $error("search match not ended");

  a_search_below: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE4]
    state_reg == tbls_pkg::ST_SRCH_BWD && first_word && key_lt
    |=> DONE && TAPE_STOP_POS == tbls_pkg::STOP_AT_NEXT)
    else $error("search low block not ended");

  a_scan_forward: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE8]
    state_reg == tbls_pkg::ST_SCAN |-> TAPE_FWD && !TAPE_BWD)
    else $error("scan moved backward");

  a_ctrl_word_drop: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE25]
    state_reg == tbls_pkg::ST_READ && !TAPE_BLK_START && blk_end && ctrl_now
    |=> !MEM_WE && DONE && DONE_CAUSE == tbls_pkg::CAUSE_CTRL)
    else $error("control word stored");

  a_preface_alarm: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE16]
    state_reg == tbls_pkg::ST_OVWR && TAPE_BLK_START && TAPE_PREFACE != preface_reg &&
    !TAPE_EOT_BLOCK |=> ALARM_MISMATCH && DONE && !TAPE_WRITE_GO)
    else $error("preface mismatch not raised");

  a_locked_unit: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE21]
    accept && unit_locked |=> ALARM_NOT_READY && DONE && !REWIND_GO && !TAPE_FWD)
    else $error("locked unit not refused");

  a_lane_no_motion: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE22]
    accept && !unit_locked && cmd_op == tbls_pkg::OP_HEAD_LANE_CHOOSE
    |=> LANE_GO && !TAPE_FWD && !TAPE_BWD && HEAD_LANE == $past(CMD_LANE))
    else $error("lane choose moved tape");

  a_read_count: assert property (@(posedge CLOCK) disable iff (RESET) // [RULE11]
    state_reg == tbls_pkg::ST_READ |->
    count_reg >= 4'h1 && count_reg <= tbls_pkg::MAX_BLOCKS)
    else $error("read count out of range");

endmodule

/* File: tbls_pkg.sv */
// Constants, opcodes and state encoding for the tape block locate sequencer
// Notes on behaviour
// [RULE1] Keyed search compares first word, signs ignored.
// [RULE2] Search runs forward until word at least key.
// [RULE3] Backward equal match ends, head reads match.
// [RULE4] Backward lower block: reverse, ready next block.
// [RULE5] Field search compares only the preloaded field.
// [RULE6] Search runs without further computer involvement.
// [RULE7] Scan checks first ten words, signs excluded.
// [RULE8] Scan moves forward, stops before matching block.
// [RULE9] Scan stops before control or end block.
// [RULE10] Field scan matches only the preloaded field.
// [RULE11] One read moves one to ten blocks.
// [RULE12] Plain read stores words at consecutive locations.
// [RULE13] Preface read stores count word before block.
// [RULE14] Read stops early on control or end block.
// [RULE15] Overwrite on fresh tape runs to physical end.
// [RULE16] Overwrite writes on preface match, else alarm; an end block with a mismatched preface ends with CAUSE_EOT and no alarm.
// [RULE17] Control and end blocks may be overwritten.
// [RULE18] Skips pass one to ten blocks autonomously.
// [RULE19] End-of-information seek stops after last block.
// [RULE20] Rewind is left to the storage unit.
// [RULE21] Locking rewind sets interlock; locked unit alarms.
// [RULE22] Lane choose switches head, no tape motion.
// [RULE23] Forward search stops at end block; backward ignores.
// [RULE24] Control block: non-end block, first sign 7.
// [RULE25] Read of control block drops its last word.
// [RULE26] Every ending signals done and returns idle.
package tbls_pkg;
  // Word layout: sign digit above ten magnitude digits, all BCD
  localparam int WORD_W = 44;
  localparam int MAG_W = 40;
  localparam int SIGN_LO = 40;
  localparam int DIGITS = 10;
  localparam logic [3:0] CTRL_SIGN = 4'h7;
  localparam logic [3:0] MAX_BLOCKS = 4'ha;
  localparam logic [3:0] SCAN_WORDS = 4'ha;
  localparam logic [4:0] FULL_FIELD = 5'h0a;
  localparam int ADDR_W = 16;
  localparam int PREF_HI = 39;
  localparam int PREF_LO = 32;

  // Instruction codes on the command port
  typedef enum logic [3:0] {
    OP_KEYED_BLOCK_SEARCH = 4'h0,
    OP_FIELD_KEYED_SEARCH = 4'h1,
    OP_CATEGORY_SCAN = 4'h2,
    OP_FIELD_CATEGORY_SCAN = 4'h3,
    OP_FIXED_LENGTH_READ = 4'h4,
    OP_READ_WITH_PREFACE = 4'h5,
    OP_BLOCK_OVERWRITE = 4'h6,
    OP_OVERWRITE_WITH_PREFACE = 4'h7,
    OP_SKIP_BLOCKS_FORWARD = 4'h8,
    OP_SKIP_BLOCKS_BACKWARD = 4'h9,
    OP_SEEK_END_OF_INFORMATION = 4'ha,
    OP_TAPE_REWIND = 4'hb,
    OP_REWIND_AND_LOCK_UNIT = 4'hc,
    OP_HEAD_LANE_CHOOSE = 4'hd
  } tbls_op_t;

  // Where the head is left when motion stops
  localparam logic STOP_AT_NEXT = 1'b0;
  localparam logic STOP_AT_THIS = 1'b1;

  // Reasons for completion
  localparam logic [2:0] CAUSE_COUNT = 3'h0;
  localparam logic [2:0] CAUSE_MATCH = 3'h1;
  localparam logic [2:0] CAUSE_CTRL = 3'h2;
  localparam logic [2:0] CAUSE_EOT = 3'h3;
  localparam logic [2:0] CAUSE_MISMATCH = 3'h4;
  localparam logic [2:0] CAUSE_NOT_READY = 3'h5;
  localparam logic [2:0] CAUSE_RUNOUT = 3'h6;
  localparam logic [2:0] CAUSE_BAD_OP = 3'h7;

  // Sequencer states, Gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SRCH_FWD = 3'b001,
    ST_SRCH_BWD = 3'b011,
    ST_SCAN = 3'b010,
    ST_READ = 3'b110,
    ST_OVWR = 3'b111,
    ST_SKIP = 3'b101,
    ST_RUNOUT = 3'b100
  } tbls_state_t;
endpackage

/* File: tbls_tape_model.sv */
// Tape unit model: streams two-word blocks in the direction the tape moves
module tbls_tape_model (
  // Clock and motion
  input wire logic clk,
  input wire logic fwd,
  input wire logic bwd,
  // Read stream
  output logic blk,
  output logic eot,
  output logic [7:0] pref,
  output logic wv,
  output logic last,
  output logic [43:0] word = 44'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  int ph = 0;
  int b;
  // Start, address word, last word; going backward the block behind is read
  always @(posedge clk) begin
    b = bwd ? pos - 1 : pos;
    blk <= (fwd || bwd) && ph == 0;
    eot <= b == 9;
    pref <= 8'h02;
    wv <= (fwd || bwd) && ph != 0;
    last <= (fwd || bwd) && ph == 2;
    // Idle word lines toggle so a stale value never passes for data
    word <= ph == 1 ? {b == 7 ? 4'h7 : 4'h0, 40'(b)} : ph == 2 ? 44'(b * 16 + 1) : ~word;
    if ((fwd || bwd) && ph == 2) pos = b + (fwd ? 1 : 0);
    ph = (fwd || bwd) ? (ph + 1) % 3 : 0;
  end
endmodule

/* File: tape_block_locate_sequencer_bench.sv */
// Self-checking bench for the tape block locate sequencer
module tape_block_locate_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_lane = 1'b1;
  logic [3:0] cmd_op = 4'h0;
  logic [3:0] cmd_count = 4'h0;
  logic [3:0] rel = 4'h0;
  logic [1:0] cmd_unit = 2'h0;
  logic [39:0] cmd_key = 40'h0;
  logic [15:0] cmd_addr = 16'h0;
  logic [7:0] cmd_spec = 8'h0;
  logic [7:0] cmd_pref = 8'h0;
  logic ready, done, al_mm, al_nr, mem_we, fwd, bwd, lane, blk, eot, wv, last, nr;
  logic [2:0] cause;
  logic [3:0] locked;
  logic [7:0] pref;
  logic [15:0] mem_addr, next_addr;
  logic [43:0] mem_data, word;
  logic [59:0] exp_q[$];
  int errors = 0;
  int samples_checked = 0;
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////
  // Design and tape unit
  tbls_sequencer i_tbls_sequencer (.CLOCK(clock), .RESET(reset), .CMD_VALID(cmd_valid),
    .CMD_READY(ready), .CMD_OP(cmd_op), .CMD_UNIT(cmd_unit), .CMD_KEY(cmd_key),
    .CMD_FIELD_SPEC(cmd_spec), .CMD_ADDR(cmd_addr), .CMD_COUNT(cmd_count),
    .CMD_PREFACE(cmd_pref), .CMD_LANE(cmd_lane), .DONE(done), .DONE_CAUSE(cause),
    .ALARM_MISMATCH(al_mm), .ALARM_NOT_READY(al_nr), .MEM_WE(mem_we), .MEM_ADDR(mem_addr),
    .MEM_DATA(mem_data), .TAPE_UNIT(), .TAPE_FWD(fwd), .TAPE_BWD(bwd), .TAPE_STOP(),
    .TAPE_STOP_POS(), .TAPE_WRITE_GO(), .REWIND_GO(), .LANE_GO(), .HEAD_LANE(lane),
    .TAPE_BLK_START(blk), .TAPE_PREFACE(pref), .TAPE_EOT_BLOCK(eot), .TAPE_WORD_VALID(wv),
    .TAPE_WORD(word), .TAPE_WORD_LAST(last), .TAPE_BLANK(1'b0), .TAPE_NEW_TAPE(1'b0),
    .TAPE_PHYS_END(1'b0), .OPERATOR_RELEASE(rel), .OPERATOR_HALT(1'b0),
    .UNIT_LOCKED(locked));
  tbls_tape_model i_tbls_tape_model (.clk(clock), .fwd(fwd), .bwd(bwd), .blk(blk),
    .eot(eot), .pref(pref), .wv(wv), .last(last), .word(word));
  ////////////////////////////////////////////////////////////////////////
  // Compare, expectations and closing
  task automatic chk(input logic [59:0] got, input logic [59:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic push(input logic [43:0] d);
    exp_q.push_back({next_addr, d});
    next_addr++;
  endtask
  // Preface word first when asked; the control word of a control block is dropped
  task automatic exp_blk(input int b, input bit pw);
    if (pw) push({4'h0, 8'h02, 32'h0});
    push({b == 7 ? 4'h7 : 4'h0, 40'(b)});
    if (b != 7) push(44'(b * 16 + 1));
  endtask
  task automatic prep;
    next_addr = 16'($urandom);
    cmd_addr <= next_addr;
  endtask
  // Held request until taken, bounded wait for completion, then cause and leftovers
  task automatic run(input logic [3:0] op, input logic [1:0] u, input logic [3:0] n,
                     input logic [2:0] c);
    int k;
    cmd_op <= op;
    cmd_unit <= u;
    cmd_count <= n;
    cmd_valid <= 1'b1;
    do @(posedge clock); while (ready !== 1'b1);
    cmd_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (done !== 1'b1 && k < 3000);
    // A missing completion is a mismatch of its own
    if (done !== 1'b1) errors++;
    nr = al_nr;
    chk(60'(cause), 60'(c));
    chk(60'(exp_q.size()), 60'h0);
    $display("test op %h finished", op);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Storage writes are popped at the falling edge, so the list is settled when run looks
  always @(negedge clock) begin
    if (mem_we === 1'b1)
      chk({mem_addr, mem_data}, exp_q.size() ? exp_q.pop_front() : 'x);
  end
  // Whole run needs well under 2000 cycles
  initial begin
    #100000;
    errors++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////
  // Tests
  initial begin
    void'($urandom(32'h7a38));
    cmd_spec <= 8'($urandom);
    cmd_pref <= 8'($urandom);
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    run(tbls_pkg::OP_HEAD_LANE_CHOOSE, 2'h0, 4'h1, tbls_pkg::CAUSE_COUNT);
    chk(60'({fwd, bwd, lane}), 60'h1);
    prep();
    exp_blk(0, 0);
    exp_blk(1, 0);
    run(tbls_pkg::OP_FIXED_LENGTH_READ, 2'h0, 4'h2, tbls_pkg::CAUSE_COUNT);
    prep();
    exp_blk(2, 1);
    exp_blk(3, 1);
    run(tbls_pkg::OP_READ_WITH_PREFACE, 2'h0, 4'h2, tbls_pkg::CAUSE_COUNT);
    cmd_key <= 40'h5;
    run(tbls_pkg::OP_KEYED_BLOCK_SEARCH, 2'h0, 4'h0, tbls_pkg::CAUSE_MATCH);
    prep();
    exp_blk(5, 0);
    exp_blk(6, 0);
    exp_blk(7, 0);
    run(tbls_pkg::OP_FIXED_LENGTH_READ, 2'h0, 4'ha, tbls_pkg::CAUSE_CTRL);
    // Key is the second word of block 8; block 9 is the end block
    cmd_key <= 40'h81;
    run(tbls_pkg::OP_CATEGORY_SCAN, 2'h0, 4'h0, tbls_pkg::CAUSE_MATCH);
    cmd_key <= 40'hff;
    run(tbls_pkg::OP_KEYED_BLOCK_SEARCH, 2'h0, 4'h0, tbls_pkg::CAUSE_EOT);
    run(tbls_pkg::OP_CATEGORY_SCAN, 2'h0, 4'h0, tbls_pkg::CAUSE_EOT);
    run(tbls_pkg::OP_SKIP_BLOCKS_BACKWARD, 2'h0, 4'h2, tbls_pkg::CAUSE_COUNT);
    cmd_pref <= 8'h05;
    run(tbls_pkg::OP_BLOCK_OVERWRITE, 2'h0, 4'h1, tbls_pkg::CAUSE_MISMATCH);
    cmd_pref <= 8'h02;
    run(tbls_pkg::OP_OVERWRITE_WITH_PREFACE, 2'h0, 4'h1, tbls_pkg::CAUSE_COUNT);
    run(tbls_pkg::OP_REWIND_AND_LOCK_UNIT, 2'h1, 4'h1, tbls_pkg::CAUSE_COUNT);
    chk(60'(locked), 60'h2);
    run(tbls_pkg::OP_FIXED_LENGTH_READ, 2'h1, 4'h1, tbls_pkg::CAUSE_NOT_READY);
    chk(60'(nr), 60'h1);
    rel <= 4'h2;
    repeat (8) @(posedge clock);
    rel <= 4'h0;
    chk(60'(locked), 60'h0);
    end_of_test();
  end
endmodule
